// file: core/shunt_cal_pkg.sv
package shunt_cal_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] OFFSET_CAL_HIGH_WORD_ADDR = 8'hC4;
  localparam logic [7:0] OFFSET_CAL_LOW_BYTE_ADDR = 8'hC5;
  localparam logic [7:0] GAIN_CAL_WORD_ADDR = 8'hC6;
  localparam logic [7:0] OVERCURRENT_COMPARE_CONFIG_ADDR = 8'hC7;
  localparam logic [7:0] HIGH_TRIP_THRESHOLD_ADDR = 8'hC8;
  localparam logic [7:0] LOW_TRIP_THRESHOLD_ADDR = 8'hC9;

  // configuration field positions
  localparam int CFG_ENABLE_BIT = 15;
  localparam int CFG_POLARITY_BIT = 14;
  localparam int CFG_SPARE_BIT = 13;
  localparam int CFG_DEGLITCH_MSB = 12;
  localparam int CFG_DEGLITCH_LSB = 8;
  localparam int OFFSET_LOW_MSB = 15;
  localparam int OFFSET_LOW_LSB = 8;

  // reset values and threshold disable codes
  localparam logic [15:0] HIGH_TRIP_THRESHOLD_RESET = 16'h7FFF;
  localparam logic [15:0] LOW_TRIP_THRESHOLD_RESET = 16'h8000;
  localparam logic [15:0] HIGH_DETECT_OFF = 16'h7FFF;
  localparam logic [15:0] LOW_DETECT_OFF = 16'h8000;

  // fast filter and gain correction
  localparam int FAST_FILTER_RATIO = 64;
  localparam int FAST_FILTER_SHIFT = 3;
  localparam int GAIN_FRACTION_BITS = 16;
  localparam logic [17:0] GAIN_UNITY = 18'h10000;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [15:0] wr_data;
  } reg_req_type;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } conv_word_type;

  // ==========================================================================
  // deglitch count decode, code to number of consecutive samples
  // ==========================================================================
  function automatic logic [6:0] deglitch_count(input logic [4:0] code);
    logic [6:0] n;
    n = 7'h01;
    if (code <= 5'h09) begin
      n = 7'(code) + 7'h01;
    end else if (code <= 5'h0E) begin
      n = 7'h0C + 7'({code - 5'h0A, 1'b0});
    end else if (code <= 5'h11) begin
      n = 7'h18 + 7'({code - 5'h0F, 2'b00});
    end else if (code <= 5'h1B) begin
      n = 7'h28 + 7'({code - 5'h12, 3'b000});
    end else begin
      n = 7'h78;
    end
    return n;
  endfunction

endpackage

// file: core/fast_sinc3_filter.sv
`timescale 1ns/10ps
`default_nettype none
module fast_sinc3_filter
  import shunt_cal_pkg::*;
#(
  parameter int ACC_WIDTH = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic enable_i,
  // modulator bitstream
  input wire logic mod_strobe_i,
  input wire logic mod_bit_i,
  // filtered sample
  output logic sample_valid_o,
  output logic [15:0] sample_o
);

  typedef struct packed {
    logic [ACC_WIDTH-1:0] int1;
    logic [ACC_WIDTH-1:0] int2;
    logic [ACC_WIDTH-1:0] int3;
    logic [ACC_WIDTH-1:0] dly1;
    logic [ACC_WIDTH-1:0] dly2;
    logic [ACC_WIDTH-1:0] dly3;
    logic [5:0] phase;
    logic valid;
    logic [15:0] sample;
  } sinc_state_type;

  sinc_state_type st;
  sinc_state_type next_st;

  logic [ACC_WIDTH-1:0] step;
  logic [ACC_WIDTH-1:0] a1;
  logic [ACC_WIDTH-1:0] a2;
  logic [ACC_WIDTH-1:0] a3;
  logic [ACC_WIDTH-1:0] c1;
  logic [ACC_WIDTH-1:0] c2;
  logic [ACC_WIDTH-1:0] c3;
  logic signed [ACC_WIDTH-1:0] scaled;

  // ==========================================================================
  // integrators at modulator rate, combs at one sample per 64 bits
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    step = mod_bit_i ? ACC_WIDTH'(1) : {ACC_WIDTH{1'b1}};
    a1 = st.int1 + step;
    a2 = st.int2 + a1;
    a3 = st.int3 + a2;
    c1 = a3 - st.dly1;
    c2 = c1 - st.dly2;
    c3 = c2 - st.dly3;
    scaled = $signed(c3) >>> FAST_FILTER_SHIFT;
    if (!enable_i) begin
      next_st = '0;
    end else if (mod_strobe_i) begin
      next_st.int1 = a1;
      next_st.int2 = a2;
      next_st.int3 = a3;
      next_st.phase = st.phase + 6'h01;
      if (st.phase == 6'(FAST_FILTER_RATIO - 1)) begin
        next_st.dly1 = a3;
        next_st.dly2 = c1;
        next_st.dly3 = c2;
        next_st.valid = 1'b1;
        if (scaled > ACC_WIDTH'(32767)) begin
          next_st.sample = 16'h7FFF;
        end else begin
          next_st.sample = scaled[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sample_valid_o = st.valid;
  assign sample_o = st.sample;

  AST_SINC_DECIMATION: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sample_valid_o |=> !sample_valid_o [*8])
    else $error("fast filter produced samples closer than the decimation ratio");

endmodule // fast_sinc3_filter
`default_nettype wire

// file: core/conversion_corrector.sv
`timescale 1ns/10ps
`default_nettype none
module conversion_corrector
  import shunt_cal_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // correction words
  input wire logic [23:0] offset_correction_word_i,
  input wire logic [15:0] gain_correction_word_i,
  // raw and corrected results
  input wire conv_word_type raw_i,
  output conv_word_type corrected_o
);

  conv_word_type st;
  conv_word_type next_st;

  logic signed [24:0] diff;
  logic signed [17:0] factor;
  logic signed [42:0] product;
  logic signed [26:0] scaled;

  // ==========================================================================
  // subtract offset, multiply by 1 + g/65536, saturate to 24 bits
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.valid = raw_i.valid;
    // offset and result share one 24-bit step, so they subtract directly
    diff = $signed({raw_i.data[23], raw_i.data})
         - $signed({offset_correction_word_i[23], offset_correction_word_i});
    factor = $signed(GAIN_UNITY + {{2{gain_correction_word_i[15]}},
                                   gain_correction_word_i});
    product = 43'(diff * factor);
    scaled = 27'(product >>> GAIN_FRACTION_BITS);
    if (raw_i.valid) begin
      if (scaled > 27'sh07FFFFF) begin
        next_st.data = 24'h7FFFFF;
      end else if (scaled < -27'sh0800000) begin
        next_st.data = 24'h800000;
      end else begin
        next_st.data = scaled[23:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign corrected_o = st;

  AST_CORRECTION_LATENCY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    raw_i.valid && offset_correction_word_i == 24'h000000 && gain_correction_word_i == 16'h0000
    |=> corrected_o.valid && corrected_o.data == $past(raw_i.data))
    else $error("neutral correction did not pass the result unchanged");

endmodule // conversion_corrector
`default_nettype wire

// file: core/shunt_cal_overcurrent.sv
`timescale 1ns/10ps
`default_nettype none
module shunt_cal_overcurrent
  import shunt_cal_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register access
  input wire reg_req_type reg_req_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // modulator bitstream of the second current converter
  input wire logic mod_strobe_i,
  input wire logic mod_bit_i,
  // main-path conversion results
  input wire conv_word_type raw_result_i,
  output conv_word_type corrected_result_o,
  // fast filter sample
  output logic fast_sample_valid_o,
  output logic [15:0] fast_sample_o,
  // comparator status
  output logic high_threshold_trip_o,
  output logic low_threshold_trip_o,
  output logic overcurrent_fault_output_o,
  // shared general-purpose pin
  input wire logic shared_pin_source_select_i,
  input wire logic shared_pin_output_format_i,
  input wire logic shared_pin_gpio_data_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_n_o
);

  typedef struct packed {
    logic [15:0] offset_high;
    logic [7:0] offset_low;
    logic [15:0] gain;
    logic comparator_enable;
    logic fault_output_polarity;
    logic cfg_spare;
    logic [4:0] deglitch_count_select;
    logic [15:0] high_trip_threshold;
    logic [15:0] low_trip_threshold;
    logic [6:0] high_count;
    logic [6:0] low_count;
    logic high_trip;
    logic low_trip;
    logic [15:0] rd_data;
    logic rd_valid;
  } block_state_type;

  localparam block_state_type BLOCK_RESET = '{
    high_trip_threshold: HIGH_TRIP_THRESHOLD_RESET,
    low_trip_threshold: LOW_TRIP_THRESHOLD_RESET,
    default: '0
  };

  block_state_type st;
  block_state_type next_st;

  logic [23:0] offset_correction_word;
  logic sample_valid;
  logic [15:0] sample;
  logic high_cond;
  logic low_cond;
  logic [6:0] needed;
  logic [7:0] high_next_cnt;
  logic [7:0] low_next_cnt;
  logic fault;

  // ==========================================================================
  // submodules
  // ==========================================================================
  assign offset_correction_word = {st.offset_high, st.offset_low};

  conversion_corrector u_corrector (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .offset_correction_word_i(offset_correction_word),
    .gain_correction_word_i(st.gain),
    .raw_i(raw_result_i),
    .corrected_o(corrected_result_o)
  );

  // only the comparator enable gates the filter, never start or stop
  fast_sinc3_filter #(
    .ACC_WIDTH(20)
  ) u_fast_filter (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(st.comparator_enable),
    .mod_strobe_i(mod_strobe_i),
    .mod_bit_i(mod_bit_i),
    .sample_valid_o(sample_valid),
    .sample_o(sample)
  );

  // ==========================================================================
  // comparator and registers
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    high_cond = (st.high_trip_threshold != HIGH_DETECT_OFF)
             && ($signed(sample) > $signed(st.high_trip_threshold));
    low_cond = (st.low_trip_threshold != LOW_DETECT_OFF)
            && ($signed(sample) < $signed(st.low_trip_threshold));
    needed = deglitch_count(st.deglitch_count_select);
    high_next_cnt = {1'b0, st.high_count} + 8'h01;
    low_next_cnt = {1'b0, st.low_count} + 8'h01;

    if (!st.comparator_enable) begin
      next_st.high_count = '0;
      next_st.low_count = '0;
      next_st.high_trip = 1'b0;
      next_st.low_trip = 1'b0;
    end else if (sample_valid) begin
      if (high_cond) begin
        if (high_next_cnt <= 8'h7F) begin
          next_st.high_count = high_next_cnt[6:0];
        end
        next_st.high_trip = st.high_trip || (high_next_cnt >= {1'b0, needed});
      end else begin
        next_st.high_count = '0;
        next_st.high_trip = 1'b0;
      end
      if (low_cond) begin
        if (low_next_cnt <= 8'h7F) begin
          next_st.low_count = low_next_cnt[6:0];
        end
        next_st.low_trip = st.low_trip || (low_next_cnt >= {1'b0, needed});
      end else begin
        next_st.low_count = '0;
        next_st.low_trip = 1'b0;
      end
    end

    if (reg_req_i.wr_en) begin
      if (reg_req_i.addr == OFFSET_CAL_HIGH_WORD_ADDR) begin
        next_st.offset_high = reg_req_i.wr_data;
      end else if (reg_req_i.addr == OFFSET_CAL_LOW_BYTE_ADDR) begin
        next_st.offset_low = reg_req_i.wr_data[OFFSET_LOW_MSB:OFFSET_LOW_LSB];
      end else if (reg_req_i.addr == GAIN_CAL_WORD_ADDR) begin
        next_st.gain = reg_req_i.wr_data;
      end else if (reg_req_i.addr == OVERCURRENT_COMPARE_CONFIG_ADDR) begin
        next_st.comparator_enable = reg_req_i.wr_data[CFG_ENABLE_BIT];
        next_st.fault_output_polarity = reg_req_i.wr_data[CFG_POLARITY_BIT];
        next_st.cfg_spare = reg_req_i.wr_data[CFG_SPARE_BIT];
        next_st.deglitch_count_select = reg_req_i.wr_data[CFG_DEGLITCH_MSB:CFG_DEGLITCH_LSB];
      end else if (reg_req_i.addr == HIGH_TRIP_THRESHOLD_ADDR) begin
        next_st.high_trip_threshold = reg_req_i.wr_data;
      end else if (reg_req_i.addr == LOW_TRIP_THRESHOLD_ADDR) begin
        next_st.low_trip_threshold = reg_req_i.wr_data;
      end
    end

    if (reg_req_i.rd_en) begin
      next_st.rd_valid = 1'b1;
      if (reg_req_i.addr == OFFSET_CAL_HIGH_WORD_ADDR) begin
        next_st.rd_data = st.offset_high;
      end else if (reg_req_i.addr == OFFSET_CAL_LOW_BYTE_ADDR) begin
        next_st.rd_data = {st.offset_low, 8'h00};
      end else if (reg_req_i.addr == GAIN_CAL_WORD_ADDR) begin
        next_st.rd_data = st.gain;
      end else if (reg_req_i.addr == OVERCURRENT_COMPARE_CONFIG_ADDR) begin
        next_st.rd_data = {st.comparator_enable, st.fault_output_polarity, st.cfg_spare,
                           st.deglitch_count_select, 8'h00};
      end else if (reg_req_i.addr == HIGH_TRIP_THRESHOLD_ADDR) begin
        next_st.rd_data = st.high_trip_threshold;
      end else if (reg_req_i.addr == LOW_TRIP_THRESHOLD_ADDR) begin
        next_st.rd_data = st.low_trip_threshold;
      end else begin
        next_st.rd_data = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= BLOCK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs and shared pin
  // ==========================================================================
  assign fault = st.high_trip || st.low_trip;
  assign overcurrent_fault_output_o = st.fault_output_polarity ? fault : !fault;
  assign high_threshold_trip_o = st.high_trip;
  assign low_threshold_trip_o = st.low_trip;
  assign fast_sample_valid_o = sample_valid;
  assign fast_sample_o = sample;
  assign rd_data_o = st.rd_data;
  assign rd_valid_o = st.rd_valid;

  // format 1 is open drain: only a low level is driven
  always_comb begin
    shared_pin_o = shared_pin_source_select_i ? overcurrent_fault_output_o
                                              : shared_pin_gpio_data_i;
    shared_pin_oe_n_o = shared_pin_output_format_i && shared_pin_o;
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_HIGH_DISABLED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sample_valid && st.high_trip_threshold == 16'h7FFF |=> !high_threshold_trip_o)
    else $error("high trip raised with high detection disabled");

  AST_LOW_DISABLED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sample_valid && st.low_trip_threshold == 16'h8000 |=> !low_threshold_trip_o)
    else $error("low trip raised with low detection disabled");

  AST_DISABLE_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !st.comparator_enable |=> !high_threshold_trip_o && !low_threshold_trip_o
      && !fast_sample_valid_o)
    else $error("comparator active while disabled");

  AST_COUNTER_RESTART: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.comparator_enable && sample_valid && !high_cond |=> st.high_count == 7'h00
      && !high_threshold_trip_o)
    else $error("deglitch counter did not restart");

  AST_SINGLE_SAMPLE_TRIP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.comparator_enable && sample_valid && low_cond && st.deglitch_count_select == 5'h00
    |=> low_threshold_trip_o)
    else $error("code zero did not trip on one sample");

  AST_NO_EARLY_TRIP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(high_threshold_trip_o) |-> {1'b0, st.high_count} >= {1'b0, needed}
      || $past(st.deglitch_count_select) != st.deglitch_count_select)
    else $error("high trip before the deglitch count was reached");

  AST_FAULT_POLARITY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(st.comparator_enable) == 1'b0 && !fault
    |-> overcurrent_fault_output_o == !st.fault_output_polarity)
    else $error("idle fault level does not match polarity");

  AST_PIN_GPIO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !shared_pin_source_select_i && !shared_pin_output_format_i
    |-> shared_pin_o == shared_pin_gpio_data_i && !shared_pin_oe_n_o)
    else $error("shared pin not carrying general-purpose data");

  AST_OFFSET_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reg_req_i.wr_en && reg_req_i.addr == OFFSET_CAL_LOW_BYTE_ADDR
    |=> offset_correction_word[7:0] == $past(reg_req_i.wr_data[15:8]))
    else $error("offset low byte not taken from bits 15 to 8");

  AST_LOW_BYTE_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reg_req_i.rd_en && reg_req_i.addr == OFFSET_CAL_LOW_BYTE_ADDR
    |=> rd_valid_o && rd_data_o[7:0] == 8'h00)
    else $error("reserved low byte of offset register not zero");

  AST_LOW_COUNTER_RESTART: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.comparator_enable && sample_valid && !low_cond |=> st.low_count == 7'h00
      && !low_threshold_trip_o)
    else $error("low deglitch counter did not restart");

  AST_LOW_NO_EARLY_TRIP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(low_threshold_trip_o) |-> {1'b0, st.low_count} >= {1'b0, needed}
      || $past(st.deglitch_count_select) != st.deglitch_count_select)
    else $error("low trip before the deglitch count was reached");

  AST_HIGH_EQUAL_NO_COUNT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.comparator_enable && sample_valid && sample == st.high_trip_threshold
    |=> st.high_count == 7'h00 && !high_threshold_trip_o)
    else $error("sample equal to high threshold counted as exceeding");

  AST_COUNT_ONLY_ON_SAMPLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.comparator_enable && !sample_valid
    |=> st.high_count == $past(st.high_count) && st.low_count == $past(st.low_count)
      && $stable(high_threshold_trip_o) && $stable(low_threshold_trip_o))
    else $error("deglitch state moved without a new fast-filter sample");

  AST_FAULT_ACTIVE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    high_threshold_trip_o || low_threshold_trip_o
    |-> overcurrent_fault_output_o == st.fault_output_polarity)
    else $error("fault output not at its active level while a trip is set");

  AST_PIN_FAULT_SOURCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    shared_pin_source_select_i |-> shared_pin_o == overcurrent_fault_output_o)
    else $error("shared pin not carrying the fault output when selected");

  AST_PIN_RELEASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    shared_pin_output_format_i && shared_pin_o |-> shared_pin_oe_n_o)
    else $error("open-drain pin driven high");

endmodule // shunt_cal_overcurrent
`default_nettype wire

// file: test/shunt_cal_overcurrent_bench.sv
`timescale 1ns/10ps
`default_nettype none
module shunt_cal_overcurrent_bench;
  import shunt_cal_pkg::*;
  // ==========================================================================
  // signals and bench state
  // ==========================================================================
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_type reg_req_i = '0;
  logic [15:0] rd_data_o;
  logic rd_valid_o;
  logic mod_strobe_i = 1'b0;
  logic mod_bit_i = 1'b0;
  conv_word_type raw_result_i = '0;
  conv_word_type corrected_result_o;
  logic fast_sample_valid_o;
  logic [15:0] fast_sample_o;
  logic high_trip;
  logic low_trip;
  logic fault;
  logic pin_sel = 1'b0;
  logic pin_fmt = 1'b0;
  logic pin_gpio = 1'b0;
  logic shared_pin_o;
  logic shared_pin_oe_n_o;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int mode = 0;
  int rh, rl, nsamp, need, scnt;
  bit mon_on = 1'b0;
  bit pend = 1'b0;
  logic [15:0] hi = 16'h7FFF;
  logic [15:0] lo = 16'h8000;
  logic pol = 1'b0;

  shunt_cal_overcurrent DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .mod_strobe_i(mod_strobe_i), .mod_bit_i(mod_bit_i),
    .raw_result_i(raw_result_i), .corrected_result_o(corrected_result_o),
    .fast_sample_valid_o(fast_sample_valid_o), .fast_sample_o(fast_sample_o),
    .high_threshold_trip_o(high_trip), .low_threshold_trip_o(low_trip),
    .overcurrent_fault_output_o(fault), .shared_pin_source_select_i(pin_sel),
    .shared_pin_output_format_i(pin_fmt), .shared_pin_gpio_data_i(pin_gpio),
    .shared_pin_o(shared_pin_o), .shared_pin_oe_n_o(shared_pin_oe_n_o)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================================
  // tasks and expectation functions
  // ==========================================================================
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #5 reg_req_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
    @(posedge clk_i);
    #5 reg_req_i = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    #5 reg_req_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 16'h0000};
    @(posedge clk_i);
    #5 reg_req_i = '0;
    chk("rd_valid", {23'h0, rd_valid_o}, 24'h000001);
    chk($sformatf("reg %h", a), {8'h00, rd_data_o}, {8'h00, exp});
  endtask

  function automatic logic [23:0] corr(logic [23:0] r, logic [23:0] o, logic [15:0] g);
    longint p;
    p = (longint'(signed'(r)) - longint'(signed'(o))) * (65536 + longint'(signed'(g)));
    p = p >>> 16;
    if (p > 64'sd8388607) p = 64'sd8388607;
    else if (p < -64'sd8388608) p = -64'sd8388608;
    return p[23:0];
  endfunction

  function automatic int dg(int c);
    if (c <= 9) return c + 1;
    if (c <= 14) return 12 + 2 * (c - 10);
    if (c <= 17) return 24 + 4 * (c - 15);
    if (c <= 27) return 40 + 8 * (c - 18);
    return 120;
  endfunction

  // ==========================================================================
  // modulator and pin stimulus, output monitor, timeout
  // ==========================================================================
  always @(posedge clk_i) begin
    #5;
    mod_strobe_i = ($urandom % 4) != 0;
    mod_bit_i = (mode == 2) ? 1'($urandom) : (mode == 1);
    pin_sel = 1'($urandom);
    pin_fmt = 1'($urandom);
    pin_gpio = 1'($urandom);
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 60000) begin
      n_fail++;
      report_and_stop();
    end
    if (!sys_rst_i) begin
      chk("pin", {23'h0, shared_pin_o}, {23'h0, pin_sel ? fault : pin_gpio});
      chk("oe_n", {23'h0, shared_pin_oe_n_o}, {23'h0, pin_fmt & shared_pin_o});
    end
    if (!mon_on) begin
      pend = 1'b0;
    end else begin
      chk("fault", {23'h0, fault}, {23'h0, pol ~^ (high_trip | low_trip)});
      if (pend) begin
        chk("high_trip", {23'h0, high_trip}, {23'h0, rh >= need});
        chk("low_trip", {23'h0, low_trip}, {23'h0, rl >= need});
      end
      pend = (fast_sample_valid_o === 1'b1);
      if (pend) begin
        if (nsamp > 0) chk("strobes", 24'(scnt), 24'd64);
        if (nsamp >= 3 && mode < 2)
          chk("sample", {8'h00, fast_sample_o}, (mode == 1) ? 24'h7FFF : 24'h8000);
        scnt = mod_strobe_i;
        rh = (hi !== 16'h7FFF && $signed(fast_sample_o) > $signed(hi)) ? rh + 1 : 0;
        rl = (lo !== 16'h8000 && $signed(fast_sample_o) < $signed(lo)) ? rl + 1 : 0;
        nsamp++;
      end else begin
        scnt += mod_strobe_i;
      end
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic [15:0] d;
    logic [23:0] off, r;
    logic [15:0] g;
    logic [7:0] addrs [6] = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9};
    logic [15:0] rstv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h7FFF, 16'h8000};
    logic [15:0] mask [6] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFFF};
    int codes [7] = '{0, 9, 10, 17, 31, 0, 3};
    void'($urandom(61));
    repeat (4) @(posedge clk_i);
    #5 sys_rst_i = 1'b0;
    for (int i = 0; i < 6; i++) rd(addrs[i], rstv[i]);
    rd(8'hB0, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom) & ((i == 3) ? 16'h7FFF : 16'hFFFF);
      wr(addrs[i], d);
      rd(addrs[i], d & mask[i]);
    end
    wr(8'hB0, 16'hFFFF);
    rd(8'hB0, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      off = 24'($urandom);
      g = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'($urandom);
      r = (i == 2) ? 24'h7FFFFF : 24'($urandom);
      if (i == 2) off = 24'h800000;
      if (i == 3) {off, g} = 40'h0000000000;
      wr(8'hC4, off[23:8]);
      wr(8'hC5, {off[7:0], 8'($urandom)});
      wr(8'hC6, g);
      @(posedge clk_i);
      #5 raw_result_i = '{valid: 1'b1, data: r};
      @(posedge clk_i);
      #5 raw_result_i.valid = 1'b0;
      chk("corr_valid", {23'h0, corrected_result_o.valid}, 24'h000001);
      chk("corr_data", corrected_result_o.data, corr(r, off, g));
    end
    codes[5] = $urandom % 32;
    for (int k = 0; k < 7; k++) begin
      mon_on = 1'b0;
      wr(8'hC7, 16'h0000);
      repeat (2) @(posedge clk_i);
      chk("off_trips", {22'h0, high_trip, low_trip}, 24'h0);
      mode = (k == 6) ? 2 : k % 2;
      hi = (mode == 1) ? {2'b00, 14'($urandom)} : (mode == 2) ? 16'h0000 : 16'h7FFF;
      lo = (mode == 0) ? {2'b11, 14'($urandom)} : (mode == 2) ? 16'hFFFF : 16'h8000;
      pol = 1'($urandom);
      wr(8'hC8, hi);
      wr(8'hC9, lo);
      need = dg(codes[k]);
      rh = 0;
      rl = 0;
      nsamp = 0;
      scnt = 0;
      wr(8'hC7, {1'b1, pol, 1'b0, 5'(codes[k]), 8'h00});
      mon_on = 1'b1;
      while (nsamp < need + 6) @(posedge clk_i);
    end
    mon_on = 1'b0;
    report_and_stop();
  end
endmodule // shunt_cal_overcurrent_bench
`default_nettype wire
